// >>> design/lane_fifo.sv
`default_nettype none

module lane_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o = (cnt_r != CW'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign level_o = cnt_r;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointers wrap naturally, so DEPTH must be a power of two
    always_comb begin
        wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = CW'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = CW'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; only written entries are ever read
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// >>> design/s2p_map.svh
`ifndef S2P_MAP_SVH
`define S2P_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_STATUS 8'h08
`define REG_CHAN_LO 8'h0c
`define REG_CHAN_HI 8'h10
`define REG_CASC 8'h14

// ****************************************
// Control field positions and reset value
// ****************************************
`define CTRL_DIR_BIT 0
`define CTRL_LATCH_BIT 1
`define CTRL_BLANK_BIT 2
`define CTRL_POL_BIT 3
`define CTRL_SRC_BIT 4
`define CTRL_PULSE_BIT 5
`define CTRL_RESET 5'h09

// ****************************************
// Status and cascade field positions
// ****************************************
`define STAT_LEVEL_LSB 0
`define STAT_EMPTY_BIT 4
`define STAT_FULL_BIT 5
`define STAT_PULSE_BIT 8
`define CASC_DIR_BIT 4

// ****************************************
// Timing
// ****************************************
`define MCLK_HZ 50000000
`define MCLK_PERIOD_NS 20
`define SHIFT_FMAX_HZ 8000000
`define SHIFT_DIV_CYC ((`MCLK_HZ + `SHIFT_FMAX_HZ - 1) / `SHIFT_FMAX_HZ)
`define LATCH_PULSE_NS 25
`define LATCH_PULSE_CYC ((`LATCH_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// >>> design/s2p_pkg.sv
`default_nettype none

package s2p_pkg;

    // Shift register contents of one lane
    typedef logic [15:0] lane_t;
    // One bit per lane
    typedef logic [3:0] nibble_t;
    // Bus slave handshake states, Gray along idle, wait, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11
    } apb_state_e;

endpackage

`default_nettype wire

// >>> design/serial_to_parallel_latched_driver.sv
// The register addresses and the APB register port were decided locally.
`include "s2p_map.svh"
`default_nettype none

module serial_to_parallel_latched_driver
    import s2p_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] lane_a_i,
    output logic [3:0] lane_a_o,
    output logic [3:0] lane_a_oe_o,
    input wire logic [3:0] lane_b_i,
    output logic [3:0] lane_b_o,
    output logic [3:0] lane_b_oe_o,
    output logic [63:0] drive_channel_o
);

    // ****************************************
    // Declarations
    // ****************************************
    apb_state_e st_r, st_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [31:0] rd_word;
    logic addr_hit;
    logic data_wr;
    logic wr_commit;

    logic dir_r, dir_nxt;
    logic latch_pass_control_n_r, latch_pass_control_n_nxt;
    logic output_blank_n_r, output_blank_n_nxt;
    logic output_polarity_n_r, output_polarity_n_nxt;
    logic src_pins_r, src_pins_nxt;
    logic [1:0] pulse_cnt_r, pulse_cnt_nxt;
    logic pulse_active;
    logic transparent;

    logic tick;
    logic fifo_in_valid, fifo_in_ready;
    logic fifo_out_valid, fifo_out_ready;
    nibble_t fifo_out_data;
    logic [3:0] fifo_level;
    logic shift_go;
    nibble_t lane_din;

    lane_t sr_r [4];
    lane_t sr_nxt [4];
    nibble_t last_nxt;
    logic [63:0] chan_nxt;
    logic [63:0] latch_q_r, latch_q_nxt;
    logic [63:0] drv_r, drv_nxt;
    logic [3:0] lane_a_r, lane_a_nxt, lane_a_oe_r, lane_a_oe_nxt;
    logic [3:0] lane_b_r, lane_b_nxt, lane_b_oe_r, lane_b_oe_nxt;
    nibble_t casc_r;

    // ****************************************
    // Outputs straight from flip-flops
    // ****************************************
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign lane_a_o = lane_a_r;
    assign lane_a_oe_o = lane_a_oe_r;
    assign lane_b_o = lane_b_r;
    assign lane_b_oe_o = lane_b_oe_r;
    assign drive_channel_o = drv_r;

    // ****************************************
    // Register bus slave
    // ****************************************

    // Address decode; unaligned or unknown offsets answer with an error
    always_comb begin
        addr_hit = 1'b1;
        rd_word = '0;
        unique case (paddr_i)
            `REG_CTRL: begin
                rd_word[`CTRL_DIR_BIT] = dir_r;
                rd_word[`CTRL_LATCH_BIT] = latch_pass_control_n_r;
                rd_word[`CTRL_BLANK_BIT] = output_blank_n_r;
                rd_word[`CTRL_POL_BIT] = output_polarity_n_r;
                rd_word[`CTRL_SRC_BIT] = src_pins_r;
            end
            `REG_DATA: rd_word = '0;
            `REG_STATUS: begin
                rd_word[`STAT_LEVEL_LSB +: 4] = fifo_level;
                rd_word[`STAT_EMPTY_BIT] = !fifo_out_valid;
                rd_word[`STAT_FULL_BIT] = !fifo_in_ready;
                rd_word[`STAT_PULSE_BIT] = pulse_active;
            end
            `REG_CHAN_LO: rd_word = drv_r[31:0];
            `REG_CHAN_HI: rd_word = drv_r[63:32];
            `REG_CASC: begin
                rd_word[3:0] = casc_r;
                rd_word[`CASC_DIR_BIT] = dir_r;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    assign data_wr = pwrite_i && (paddr_i == `REG_DATA);
    // Writes land only at the edge where the master samples pready high
    assign wr_commit = (st_r == ST_DONE) && psel_i && penable_i && pwrite_i && addr_hit;
    assign fifo_in_valid = wr_commit && (paddr_i == `REG_DATA);

    // Handshake: a data write waits in ST_WAIT while the FIFO is full
    always_comb begin
        st_nxt = st_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        unique case (st_r)
            ST_IDLE: begin
                if (psel_i && !penable_i) begin
                    st_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!psel_i) begin
                    st_nxt = ST_IDLE;
                end else if (penable_i && (!data_wr || fifo_in_ready)) begin
                    st_nxt = ST_DONE;
                    pready_nxt = 1'b1;
                    pslverr_nxt = !addr_hit;
                    prdata_nxt = pwrite_i ? 32'h0000_0000 : rd_word;
                end
            end
            ST_DONE: begin
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= ST_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Control register and latch pulse
    // ****************************************

    // Pulse command gives a transparent window no shorter than the latch minimum
    always_comb begin
        dir_nxt = dir_r;
        latch_pass_control_n_nxt = latch_pass_control_n_r;
        output_blank_n_nxt = output_blank_n_r;
        output_polarity_n_nxt = output_polarity_n_r;
        src_pins_nxt = src_pins_r;
        pulse_cnt_nxt = pulse_active ? 2'(pulse_cnt_r - 1'b1) : pulse_cnt_r;
        if (wr_commit && (paddr_i == `REG_CTRL)) begin
            dir_nxt = pwdata_i[`CTRL_DIR_BIT];
            latch_pass_control_n_nxt = pwdata_i[`CTRL_LATCH_BIT];
            output_blank_n_nxt = pwdata_i[`CTRL_BLANK_BIT];
            output_polarity_n_nxt = pwdata_i[`CTRL_POL_BIT];
            src_pins_nxt = pwdata_i[`CTRL_SRC_BIT];
            if (pwdata_i[`CTRL_PULSE_BIT]) begin
                pulse_cnt_nxt = 2'(`LATCH_PULSE_CYC);
            end
        end
    end

    assign pulse_active = (pulse_cnt_r != 2'h0);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_r <= 1'b1;
            latch_pass_control_n_r <= 1'b0;
            output_blank_n_r <= 1'b0;
            output_polarity_n_r <= 1'b1;
            src_pins_r <= 1'b0;
            pulse_cnt_r <= 2'h0;
        end else begin
            dir_r <= dir_nxt;
            latch_pass_control_n_r <= latch_pass_control_n_nxt;
            output_blank_n_r <= output_blank_n_nxt;
            output_polarity_n_r <= output_polarity_n_nxt;
            src_pins_r <= src_pins_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
        end
    end

    // ****************************************
    // Shift rate and data buffer
    // ****************************************
    shift_tick_div u_div (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    lane_fifo #(
        .WIDTH(4),
        .DEPTH(8)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pwdata_i[3:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data),
        .level_o(fifo_level)
    );

    // In pin mode every tick shifts; in buffer mode a tick shifts only when data is waiting, else it is skipped
    assign fifo_out_ready = tick && !src_pins_r;
    assign shift_go = tick && (src_pins_r || fifo_out_valid);
    // Feeding side of the lane pins follows the direction
    assign lane_din = src_pins_r ? (dir_r ? lane_a_i : lane_b_i) : fifo_out_data;

    // ****************************************
    // Shift registers and channel map
    // ****************************************
    for (genvar k = 0; k < 4; k++) begin : g_lane
        // All four lanes share one shift enable
        assign sr_nxt[k] = !shift_go ? sr_r[k] :
            dir_r ? {sr_r[k][14:0], lane_din[k]} :
            {lane_din[k], sr_r[k][15:1]};
        // Far end under the coming direction, so a swap never shows a stale end
        assign last_nxt[k] = dir_nxt ? sr_nxt[k][15] : sr_nxt[k][0];
        // Stage s of lane k lands on channel 4*s+k (zero based)
        for (genvar s = 0; s < 16; s++) begin : g_stage
            assign chan_nxt[4*s+k] = sr_nxt[k][s];
        end
    end

    // Reset only for clean simulation; content is junk until a frame is latched
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < 4; k++) begin
                sr_r[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 4; k++) begin
                sr_r[k] <= sr_nxt[k];
            end
        end
    end

    // ****************************************
    // Latches, polarity and blanking
    // ****************************************
    assign transparent = latch_pass_control_n_r || pulse_active;

    // Latch follows next shift value so it never trails the register by a cycle
    always_comb begin
        latch_q_nxt = latch_q_r;
        if (transparent) begin
            latch_q_nxt = chan_nxt;
        end
        drv_nxt = latch_q_nxt ^ {64{!output_polarity_n_nxt}};
        if (!output_blank_n_nxt) begin
            drv_nxt = {64{!output_polarity_n_nxt}};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_q_r <= '0;
            drv_r <= '0;
        end else begin
            latch_q_r <= latch_q_nxt;
            drv_r <= drv_nxt;
        end
    end

    // ****************************************
    // Cascade lanes
    // ****************************************

    // Lane i out carries register 3-i, mirroring the feeding pin order
    always_comb begin
        lane_a_nxt = 4'h0;
        lane_b_nxt = 4'h0;
        for (int i = 0; i < 4; i++) begin
            lane_a_nxt[i] = dir_nxt ? 1'b0 : last_nxt[3-i];
            lane_b_nxt[i] = dir_nxt ? last_nxt[3-i] : 1'b0;
        end
        lane_a_oe_nxt = dir_nxt ? 4'h0 : 4'hf;
        lane_b_oe_nxt = dir_nxt ? 4'hf : 4'h0;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lane_a_r <= 4'h0;
            lane_b_r <= 4'h0;
            lane_a_oe_r <= 4'h0;
            lane_b_oe_r <= 4'hf;
            casc_r <= 4'h0;
        end else begin
            lane_a_r <= lane_a_nxt;
            lane_b_r <= lane_b_nxt;
            lane_a_oe_r <= lane_a_oe_nxt;
            lane_b_oe_r <= lane_b_oe_nxt;
            casc_r <= last_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> design/shift_tick_div.sv
`include "s2p_map.svh"
`default_nettype none

module shift_tick_div (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    output logic tick_o
);

    logic [2:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;

    assign tick_o = tick_r;

    // One enable pulse every SHIFT_DIV_CYC cycles keeps each lane under its maximum rate
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = 3'(cnt_r + 1'b1);
        if (cnt_r == 3'(`SHIFT_DIV_CYC - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> test/lane_host.sv
`default_nettype none
// ********
// Controller side of the serial lanes
// ********
module lane_host (
    input wire logic [3:0] pattern_i,
    input wire logic [3:0] dev_a_i,
    input wire logic [3:0] dev_a_oe_i,
    input wire logic [3:0] dev_b_i,
    input wire logic [3:0] dev_b_oe_i,
    output logic [3:0] wire_a_o,
    output logic [3:0] wire_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Controller feeds only the side the device leaves undriven
    assign wire_a_o = (dev_a_oe_i & dev_a_i) | (~dev_a_oe_i & pattern_i);
    assign wire_b_o = (dev_b_oe_i & dev_b_i) | (~dev_b_oe_i & pattern_i);
endmodule
`default_nettype wire

// >>> test/s2p_sva.sv
`default_nettype none
// ********
// Bus handshake and lane checks
// ********
module s2p_sva (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [3:0] lane_a_oe_o,
    input wire logic [3:0] lane_b_o,
    input wire logic [3:0] lane_b_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Unaligned or past the last register
    logic bad;
    assign bad = (paddr_i[1:0] != 2'h0) || (paddr_i > 8'h14);
    // Data pushes may stall on a full buffer, so they are left out
    sequence s_setup_ok;
        psel_i && !penable_i && !bad && paddr_i != 8'h04;
    endsequence
    sequence s_setup_bad;
        psel_i && !penable_i && bad;
    endsequence
    // Guard of one cycle keeps a direction swap out of the window
    sequence s_cascade_move;
        lane_b_oe_o == 4'hf ##1 (lane_b_oe_o == 4'hf && $changed(lane_b_o));
    endsequence
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside an access phase");
    a_answer_time: assert property (s_setup_ok |-> ##2 (pready_o && !pslverr_o))
        else $error("mapped access not answered after one wait");
    a_unmapped_err: assert property (s_setup_bad |-> ##2 (pready_o && pslverr_o && prdata_o == 32'h0))
        else $error("unmapped access not refused");
    a_rdata_hold: assert property ($changed(prdata_o) |-> pready_o)
        else $error("read data moved without an answer");
    a_lane_roles: assert property ((lane_a_oe_o == 4'h0 && lane_b_oe_o == 4'hf) ||
        (lane_a_oe_o == 4'hf && lane_b_oe_o == 4'h0))
        else $error("lane sides not in opposite roles");
    a_cascade_still: assert property (s_cascade_move |=>
        ($stable(lane_b_o) || lane_b_oe_o != 4'hf)[*5])
        else $error("cascade output moved between shifts");
endmodule
bind serial_to_parallel_latched_driver s2p_sva i_sva (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .paddr_i(paddr_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .lane_a_oe_o(lane_a_oe_o),
    .lane_b_o(lane_b_o),
    .lane_b_oe_o(lane_b_oe_o)
);
`default_nettype wire

// >>> test/tb_serial_to_parallel_latched_driver.sv
`default_nettype none
module tb_serial_to_parallel_latched_driver
    import s2p_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_s;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [3:0] lane_a_i, lane_a_o, lane_a_oe_o, lane_b_i, lane_b_o, lane_b_oe_o;
    logic [63:0] drive_channel_o;
    nibble_t pattern = 4'h1;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    logic [63:0] fa;
    logic [63:0] fb;
    // ********
    // Ordinary register accesses: address, write, data, read value, error
    // ********
    row_s rows [12] = '{
        '{8'h00, 1'b1, 32'h01, 32'h0, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'hffffffff, 1'b0},
        '{8'h00, 1'b1, 32'h09, 32'h0, 1'b0},
        '{8'h10, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h00, 1'b1, 32'h3f, 32'h0, 1'b0},
        '{8'h00, 1'b0, 32'h0, 32'h1f, 1'b0},
        '{8'h18, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h02, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h08, 1'b1, 32'h3f, 32'h0, 1'b0},
        '{8'h08, 1'b0, 32'h0, 32'h10, 1'b0},
        '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h1c, 1'b1, 32'h5, 32'h0, 1'b1}
    };
    serial_to_parallel_latched_driver i_serial_to_parallel_latched_driver (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .lane_a_i(lane_a_i),
        .lane_a_o(lane_a_o), .lane_a_oe_o(lane_a_oe_o), .lane_b_i(lane_b_i),
        .lane_b_o(lane_b_o), .lane_b_oe_o(lane_b_oe_o), .drive_channel_o(drive_channel_o)
    );
    lane_host i_lane_host (
        .pattern_i(pattern), .dev_a_i(lane_a_o), .dev_a_oe_i(lane_a_oe_o),
        .dev_b_i(lane_b_o), .dev_b_oe_i(lane_b_oe_o), .wire_a_o(lane_a_i), .wire_b_o(lane_b_i)
    );
    // 50 MHz clock
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One transfer; request held until ready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) begin
            @(posedge mclk_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Word j of a frame is j xor key; direction picks its final stage
    function automatic logic [63:0] frame(input logic dir, input logic [3:0] key);
        logic [63:0] f;
        f = '0;
        for (int j = 0; j < 16; j++) begin
            f[4*(dir ? 15-j : j) +: 4] = 4'(j) ^ key;
        end
        return f;
    endfunction
    task automatic push(input logic [3:0] key, input int first, input int last);
        for (int j = first; j <= last; j++) begin
            apb(8'h04, 1'b1, {28'h0, 4'(j) ^ key});
        end
    endtask
    // Empty buffer means the last word has shifted in
    task automatic drain();
        apb(8'h08, 1'b0, 32'h0);
        while (rd[4] !== 1'b1) begin
            apb(8'h08, 1'b0, 32'h0);
        end
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic reset_pins();
        check("drive", 64'h0, drive_channel_o);
        check("oe_a", 4'h0, lane_a_oe_o);
        check("oe_b", 4'hf, lane_b_oe_o);
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        fa = frame(1'b1, 4'h3);
        fb = frame(1'b0, 4'h5);
        repeat (16) @(posedge mclk_i);
        reset_pins();
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            check("pslverr", rows[i].e, er);
            if (!rows[i].w) begin
                check("prdata", rows[i].x, rd);
            end
        end
        // Pin lanes feed while the buffer fills without draining
        apb(8'h00, 1'b1, 32'h1d);
        push(4'h3, 0, 7);
        apb(8'h08, 1'b0, 32'h0);
        check("status_full", 32'h28, rd);
        repeat (119) @(posedge mclk_i);
        check("cascade_pin", 4'h8, lane_b_o);
        apb(8'h14, 1'b0, 32'h0);
        check("casc", 32'h11, rd);
        // Rest of the frame stalls on a full buffer
        apb(8'h00, 1'b1, 32'h0d);
        push(4'h3, 8, 15);
        drain();
        check("cascade_a", 4'hc, lane_b_o);
        apb(8'h00, 1'b1, 32'h2d);
        repeat (4) @(posedge mclk_i);
        check("frame_a", fa, drive_channel_o);
        // Reverse direction while latches hold
        apb(8'h00, 1'b1, 32'h0c);
        // Enables move on the commit edge itself, so look one edge later
        @(posedge mclk_i);
        check("oe_a_rev", 4'hf, lane_a_oe_o);
        push(4'h5, 0, 15);
        drain();
        check("held", fa, drive_channel_o);
        check("cascade_b", 4'ha, lane_a_o);
        apb(8'h00, 1'b1, 32'h24);
        repeat (4) @(posedge mclk_i);
        check("frame_b", ~fb, drive_channel_o);
        // Transparent latches follow one more shift
        apb(8'h00, 1'b1, 32'h06);
        apb(8'h04, 1'b1, 32'h9);
        drain();
        check("follow", ~{4'h9, fb[63:4]}, drive_channel_o);
        // Reset in mid-run
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        reset_pins();
        rst_n_i <= 1'b1;
        apb(8'h00, 1'b0, 32'h0);
        check("ctrl_reset", 32'h09, rd);
        tally_and_finish();
    end
endmodule
`default_nettype wire
